// ==== src/dma_resp_pkg.sv ====
// package for the cache DMA response framer and its outbound receiver
// assumes both ends and the link carrier import it whole
package dma_resp_pkg;

    // ==========================================================
    // packet geometry
    localparam int WORD_W      = 32;  // one link word per clock
    localparam int LINE_WORDS  = 16;  // 64-byte line in 32-bit words
    localparam int STORE_DUMMY = 8;   // dummy cycles after a store header
    localparam int PAD_CYCLES  = 8;   // quiet cycles after a store response
    localparam int PKT_WORDS   = 17;  // header plus longest body
    localparam int FIFO_DEPTH  = 32;  // receive buffer depth
    localparam int ROOM_SLACK  = 2;   // words in flight behind the room flag
    localparam int CHECK_W     = 6;   // tag check bits

    // ==========================================================
    // header word field positions
    localparam int HDR_TEST_BIT  = 31;  // test-controller access
    localparam int HDR_ORD_BIT   = 23;  // ordered queue
    localparam int HDR_POST_BIT  = 22;  // posted
    localparam int HDR_ERR_BIT   = 21;  // error carried from request
    localparam int HDR_SRC_BIT   = 20;  // 1 pcie dma unit, 0 network dma
    localparam int HDR_CBO_LSB   = 17;  // critical byte offset [19:17]
    localparam int HDR_READ_BIT  = 16;  // read indicator
    localparam int HDR_TAG_LSB   = 0;   // tag [15:0]

    // ==========================================================
    // reset values
    localparam logic [WORD_W-1:0]  WORD_RST  = 32'h0000_0000;
    localparam logic [CHECK_W-1:0] CHECK_RST = 6'h00;

    // ==========================================================
    // tag check bit masks, one parity group per check bit
    localparam logic [15:0] CHECK_MASK [CHECK_W] = '{
        16'hAD5B, 16'h366D, 16'hC78E, 16'h07F0, 16'hF800, 16'hFFFF
    };

    // parity over each masked group of the tag
    function automatic logic [CHECK_W-1:0] tag_check(input logic [15:0] tag);
        logic [CHECK_W-1:0] c;
        c = CHECK_RST;
        for (int i = 0; i < CHECK_W; i++) begin
            c[i] = ^(tag & CHECK_MASK[i]);
        end
        return c;
    endfunction : tag_check

    // ==========================================================
    // framer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HEAD = 3'b001,
        ST_BODY = 3'b010,
        ST_PAD  = 3'b011
    } frame_state_e;

endpackage : dma_resp_pkg

// ==== src/resp_link_if.sv ====
// carrier joining the response framer to the outbound receiver
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface resp_link_if;
    import dma_resp_pkg::*;

    logic                 sop;        // header cycle marker
    logic                 data_valid; // payload word qualifier
    logic [WORD_W-1:0]    data;       // header or payload word
    logic [CHECK_W-1:0]   check;      // tag check bits, header cycle
    logic                 fatal;      // cache fatal error flag, header cycle
    logic                 busy;       // a packet is on the link
    logic                 room;       // receiver can take a whole packet

    // ==========================================================
    // one modport per party
    modport dev_end  (output sop, data_valid, data, check, fatal, busy, input  room);
    modport host_end (input  sop, data_valid, data, check, fatal, busy, output room);
endinterface : resp_link_if
`default_nettype wire

// ==== src/resp_fifo.sv ====
// receive buffer with valid and ready on both sides
// assumes a single clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module resp_fifo #(
    parameter int W     = 33,
    parameter int DEPTH = 32
) (
    input  wire logic                     clk_sys_i,  // system clock
    input  wire logic                     rst_i,      // async reset
    input  wire logic                     in_valid_i, // push request
    output logic                          in_ready_o, // not full
    input  wire logic [W-1:0]             in_data_i,  // pushed word
    output logic                          out_valid_o,// not empty
    input  wire logic                     out_ready_i,// pop request
    output logic [W-1:0]                  out_data_o, // head word
    output logic [$clog2(DEPTH+1)-1:0]    count_o     // words held
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]              mem [DEPTH];
    logic [AW-1:0]             wr_ptr;
    logic [AW-1:0]             rd_ptr;
    logic [$clog2(DEPTH+1)-1:0] count;
    logic                      push;
    logic                      pop;

    // ==========================================================
    // handshakes
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign in_ready_o  = (count != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign count_o     = count;

    // storage write
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : resp_fifo
`default_nettype wire

// ==== src/cache_dma_response_framer.sv ====
// shared cache end: frames DMA responses onto the outbound link
// assumes requests arrive with their line already read and the
// receiver keeps room high only when a whole packet fits
//
// Functional notes
// - line read returns 64 bytes, critical first
// - first word chosen by address bits 5:2
// - ascending words, wrap to line start
// - read header bit 16 is one
// - header echoes the 16-bit tag unchanged
// - read header echoes address bits 2:0
// - ordered, posted, source copied back unchanged
// - receiver forwards read error downstream
// - header carries cache fatal error flag
// - header carries check bits over tag
// - header carries test-access flag
// - legal read: not posted, offset zero
// - store response: header plus eight dummies
// - eight pad cycles after store response
// - receiver drops posted store responses
// - store error forwarded only when not posted
// - store header bits 19:16 are zero
// - legal pcie store: posted and ordered
// - ordered and posted flag meanings kept
`timescale 1ns/1ps
`default_nettype none
module cache_dma_response_framer
    import dma_resp_pkg::*;
#(
    parameter int LINE_W = 512
) (
    input  wire logic              clk_sys_i,     // system clock
    input  wire logic              rst_i,         // async reset
    input  wire logic              req_valid_i,   // response request
    output logic                   req_ready_o,   // framer can take one
    input  wire logic              req_read_i,    // 1 line read, 0 full line store
    input  wire logic [5:0]        req_addr_i,    // physical address bits 5:0
    input  wire logic [15:0]       req_tag_i,     // transaction tag
    input  wire logic              req_ordered_i, // ordered queue flag
    input  wire logic              req_posted_i,  // posted flag
    input  wire logic              req_source_i,  // 1 pcie dma, 0 network dma
    input  wire logic              req_error_i,   // error carried from request
    input  wire logic              req_test_i,    // test-controller access
    input  wire logic              req_fatal_i,   // cache detected fatal error
    input  wire logic [LINE_W-1:0] req_line_i,    // cache line, word 0 lowest
    resp_link_if.dev_end           link           // outbound link
);

    // ==========================================================
    // captured request
    frame_state_e          state;
    logic                  is_read;
    logic [3:0]            first_word;
    logic [2:0]            crit_offset;
    logic [15:0]           tag;
    logic                  ordered;
    logic                  posted;
    logic                  source;
    logic                  error;
    logic                  test_acc;
    logic                  fatal;
    logic [LINE_W-1:0]     line;
    logic [3:0]            beat;
    logic [3:0]            word_idx;
    logic [WORD_W-1:0]     header;
    logic                  accept;

    // output flops feeding the link
    logic                  sop;
    logic                  data_valid;
    logic [WORD_W-1:0]     data;
    logic [CHECK_W-1:0]    check;
    logic                  fatal_out;
    logic                  busy;

    // ==========================================================
    // request handshake
    assign accept = req_valid_i && req_ready_o;

    // current payload word: start word plus beat, wrapping mod 16
    assign word_idx = first_word + beat;

    // ==========================================================
    // header word assembly
    always_comb begin
        header                = WORD_RST;
        header[HDR_TEST_BIT]  = test_acc;
        header[HDR_ORD_BIT]   = ordered;
        header[HDR_POST_BIT]  = posted;
        header[HDR_ERR_BIT]   = error;
        header[HDR_SRC_BIT]   = source;
        header[HDR_TAG_LSB +: 16] = tag;
        if (is_read) begin
            header[HDR_CBO_LSB +: 3] = crit_offset;
            header[HDR_READ_BIT]     = 1'b1;
        end else begin
            header[HDR_CBO_LSB +: 3] = 3'h0;
            header[HDR_READ_BIT]     = 1'b0;
        end
    end

    // ==========================================================
    // request capture; flags are stored, never interpreted
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            is_read     <= 1'b0;
            first_word  <= 4'h0;
            crit_offset <= 3'h0;
            tag         <= 16'h0000;
            ordered     <= 1'b0;
            posted      <= 1'b0;
            source      <= 1'b0;
            error       <= 1'b0;
            test_acc    <= 1'b0;
            fatal       <= 1'b0;
            line        <= '0;
        end else if (accept) begin
            is_read     <= req_read_i;
            first_word  <= req_addr_i[5:2];
            crit_offset <= req_addr_i[2:0];
            tag         <= req_tag_i;
            ordered     <= req_ordered_i;
            posted      <= req_posted_i;
            source      <= req_source_i;
            error       <= req_error_i;
            test_acc    <= req_test_i;
            fatal       <= req_fatal_i;
            line        <= req_line_i;
        end
    end

    // ==========================================================
    // sequencing: idle, header, body, pad
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            beat  <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    beat <= 4'h0;
                    if (accept) begin
                        state <= ST_HEAD;
                    end
                end
                ST_HEAD: begin
                    state <= ST_BODY;
                end
                ST_BODY: begin
                    beat <= beat + 4'h1;
                    if (is_read && beat == 4'(LINE_WORDS - 1)) begin
                        state <= ST_IDLE;
                    end else if (!is_read && beat == 4'(STORE_DUMMY - 1)) begin
                        state <= ST_PAD;
                        beat  <= 4'h0;
                    end
                end
                ST_PAD: begin
                    beat <= beat + 4'h1;
                    if (beat == 4'(PAD_CYCLES - 1)) begin
                        state <= ST_IDLE;
                        beat  <= 4'h0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    beat  <= 4'h0;
                end
            endcase
        end
    end

    // ==========================================================
    // request ready: only when idle and the receiver has room
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            req_ready_o <= 1'b0;
        end else begin
            req_ready_o <= (state == ST_IDLE) && !accept && link.room;
        end
    end

    // ==========================================================
    // link word drive, one word per clock
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sop        <= 1'b0;
            data_valid <= 1'b0;
            data       <= WORD_RST;
            check      <= CHECK_RST;
            fatal_out  <= 1'b0;
            busy       <= 1'b0;
        end else begin
            sop        <= 1'b0;
            data_valid <= 1'b0;
            data       <= WORD_RST;
            check      <= CHECK_RST;
            fatal_out  <= 1'b0;
            busy       <= 1'b0;
            case (state)
                ST_HEAD: begin
                    sop       <= 1'b1;
                    data      <= header;
                    check     <= tag_check(tag);
                    fatal_out <= fatal;
                    busy      <= 1'b1;
                end
                ST_BODY: begin
                    busy <= 1'b1;
                    if (is_read) begin
                        data_valid <= 1'b1;
                        data       <= line[word_idx*WORD_W +: WORD_W];
                    end
                    // store dummies stay invalid with zero data
                end
                default: begin
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // link outputs straight from the flops above
    assign link.sop        = sop;
    assign link.data_valid = data_valid;
    assign link.data       = data;
    assign link.check      = check;
    assign link.fatal      = fatal_out;
    assign link.busy       = busy;

endmodule : cache_dma_response_framer
`default_nettype wire

// ==== src/outbound_response_receiver.sv ====
// outbound end: takes framed responses, drops what is not forwarded,
// buffers the rest and reports errors toward the issuing DMA unit
// assumes the framer waits for room before starting a packet
`timescale 1ns/1ps
`default_nettype none
module outbound_response_receiver
    import dma_resp_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              clk_sys_i,    // system clock
    input  wire logic              rst_i,        // async reset
    resp_link_if.host_end          link,         // outbound link
    output logic                   out_valid_o,  // buffered word ready
    input  wire logic              out_ready_i,  // downstream takes word
    output logic                   out_sop_o,    // word is a header
    output logic [WORD_W-1:0]      out_data_o,   // header or payload
    output logic                   err_o,        // error pulse downstream
    output logic                   err_source_o  // 1 pcie dma, 0 network dma
);
    localparam int CW = $clog2(DEPTH+1);

    logic              hdr_read;
    logic              hdr_posted;
    logic              hdr_err;
    logic              keep;
    logic              push;
    logic              in_ready;
    logic              fifo_valid;
    logic [WORD_W:0]   fifo_data;
    logic [CW-1:0]     count;
    logic              room;
    logic              pop;

    // ==========================================================
    // header decode; posted stores are never buffered
    assign hdr_read   = link.data[HDR_READ_BIT];
    assign hdr_posted = link.data[HDR_POST_BIT];
    assign hdr_err    = link.data[HDR_ERR_BIT];
    assign keep       = link.sop ? (hdr_read || !hdr_posted) : link.data_valid;
    assign push       = (link.sop || link.data_valid) && keep;

    resp_fifo #(
        .W     (WORD_W + 1),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (push),
        .in_ready_o  (in_ready),
        .in_data_i   ({link.sop, link.data}),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_data),
        .count_o     (count)
    );

    // output stage: one registered word, refilled when empty or taken
    assign pop = fifo_valid && (!out_valid_o || out_ready_i);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            out_sop_o   <= 1'b0;
            out_data_o  <= WORD_RST;
        end else if (pop) begin
            out_valid_o <= 1'b1;
            out_sop_o   <= fifo_data[WORD_W];
            out_data_o  <= fifo_data[WORD_W-1:0];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end

    // room for a whole packet plus words in flight
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            room <= 1'b0;
        end else begin
            room <= in_ready && (count <= CW'(DEPTH - PKT_WORDS - ROOM_SLACK));
        end
    end
    assign link.room = room;

    // error forwarding: reads always, stores only when not posted
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            err_o        <= 1'b0;
            err_source_o <= 1'b0;
        end else begin
            err_o <= link.sop && hdr_err && (hdr_read || !hdr_posted);
            if (link.sop && hdr_err) begin
                err_source_o <= link.data[HDR_SRC_BIT];
            end
        end
    end
endmodule : outbound_response_receiver
`default_nettype wire

// ==== verification/cache_dma_response_framer_asserts.sv ====
// checker for the response link between framer and receiver
// assumes instantiation beside the link carrier, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cache_dma_response_framer_asserts
    import dma_resp_pkg::*;
(
    input  wire logic               clk_sys_i,  // system clock
    input  wire logic               rst_i,      // async reset
    input  wire logic               sop,        // header marker
    input  wire logic               data_valid, // payload qualifier
    input  wire logic [WORD_W-1:0]  data,       // link word
    input  wire logic [CHECK_W-1:0] check,      // tag check bits
    input  wire logic               busy        // packet on link
);
    // ==========================================================
    // clocking and helpers
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // parity groups over the header tag
    function automatic logic [CHECK_W-1:0] exp_check(input logic [15:0] t);
        logic [CHECK_W-1:0] c;
        for (int i = 0; i < CHECK_W; i++) begin
            c[i] = ^(t & CHECK_MASK[i]);
        end
        return c;
    endfunction : exp_check

    // ==========================================================
    // framing of each packet
    AST_READ_BODY: assert property (
        sop && data[HDR_READ_BIT] |=> data_valid[*8] ##1 data_valid[*8] ##1 !data_valid)
        else $error("read body is not sixteen back-to-back words");
    AST_STORE_DUMMY: assert property (
        sop && !data[HDR_READ_BIT] |=> (busy && !data_valid && !sop)[*8])
        else $error("store body is not eight dummy cycles");
    AST_STORE_PAD: assert property (
        sop && !data[HDR_READ_BIT] |-> ##9 (!sop)[*8])
        else $error("next packet inside store pad");
    AST_STORE_BITS: assert property (
        sop && !data[HDR_READ_BIT] |-> data[19:16] == 4'h0)
        else $error("store header bits 19:16 not zero");
    AST_CHECK_BITS: assert property (
        sop |-> check == exp_check(data[15:0]))
        else $error("tag check bits wrong");
    AST_SOP_PULSE: assert property (
        $rose(sop) |=> $fell(sop))
        else $error("header marker longer than one cycle");
    AST_SOP_ALONE: assert property (
        sop |-> !data_valid && busy)
        else $error("header cycle qualified as payload");
    AST_VALID_BUSY: assert property (
        data_valid |-> busy && !sop)
        else $error("payload word outside a packet");
endmodule : cache_dma_response_framer_asserts
`default_nettype wire

// ==== verification/cache_dma_response_framer_test.sv ====
// self-checking bench: framer and receiver joined by the link carrier
// assumes the package, carrier, buffer and both ends compiled first
`timescale 1ns/1ps
`default_nettype none
module cache_dma_response_framer_test
    import dma_resp_pkg::*;
;
    // ==========================================================
    // signals and rows
    typedef struct packed {
        logic       rd;   // line read
        logic [5:0] addr; // address bits 5:0
        logic [15:0] tag; // transaction tag
        logic [5:0] fl;   // ordered posted source error test fatal
        logic [1:0] ex;   // header forwarded, error pulse
    } row_s;
    logic              clk_sys_i, rst_i, req_valid_i, req_ready_o, req_read_i;
    logic              req_ordered_i, req_posted_i, req_source_i, req_error_i;
    logic              req_test_i, req_fatal_i, out_ready_i, out_valid_o;
    logic              out_sop_o, err_o, err_source_o;
    logic [5:0]        req_addr_i;
    logic [15:0]       req_tag_i;
    logic [511:0]      req_line_i;
    logic [WORD_W-1:0] out_data_o;
    int                num_errors, n_checks, n_hdr, n_err, n_out, n0;
    row_s rows [8] = '{
        '{1'b1, 6'h00, 16'h1234, 6'b101000, 2'b10}, '{1'b1, 6'h2D, 16'hBEEF, 6'b000000, 2'b10},
        '{1'b1, 6'h3C, 16'h0001, 6'b100110, 2'b11}, '{1'b1, 6'h07, 16'hFFFF, 6'b001001, 2'b10},
        '{1'b0, 6'h00, 16'hA5A5, 6'b111000, 2'b00}, '{1'b0, 6'h00, 16'h5A5A, 6'b000100, 2'b11},
        '{1'b0, 6'h00, 16'h8001, 6'b111100, 2'b00}, '{1'b1, 6'h01, 16'h0F0F, 6'b000100, 2'b11}};

    resp_link_if resp_link_if_i ();
    cache_dma_response_framer cache_dma_response_framer_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_read_i(req_read_i),
        .req_addr_i(req_addr_i), .req_tag_i(req_tag_i), .req_ordered_i(req_ordered_i),
        .req_posted_i(req_posted_i), .req_source_i(req_source_i), .req_error_i(req_error_i),
        .req_test_i(req_test_i), .req_fatal_i(req_fatal_i), .req_line_i(req_line_i), .link(resp_link_if_i));
    outbound_response_receiver outbound_response_receiver_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .link(resp_link_if_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_sop_o(out_sop_o),
        .out_data_o(out_data_o), .err_o(err_o), .err_source_o(err_source_o));
    cache_dma_response_framer_asserts cache_dma_response_framer_asserts_i (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .sop(resp_link_if_i.sop), .data_valid(resp_link_if_i.data_valid),
        .data(resp_link_if_i.data), .check(resp_link_if_i.check), .busy(resp_link_if_i.busy));

    // clock and downstream counters
    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (out_valid_o === 1'b1 && out_ready_i === 1'b1) n_out++;
        if (out_valid_o === 1'b1 && out_ready_i === 1'b1 && out_sop_o === 1'b1) n_hdr++;
        if (err_o === 1'b1) n_err++;
    end

    // ==========================================================
    // tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report

    task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    // waits for ready (sel 0) or a header on the link (sel 1)
    task automatic wait_hi(input logic sel);
        int k;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while ((sel ? resp_link_if_i.sop : req_ready_o) !== 1'b1 && k < 100);
        if (k >= 100) begin
            num_errors++;
            final_report();
        end
    endtask : wait_hi

    // one request through the framer and out of the receiver
    task automatic run_row(input row_s r);
        logic [WORD_W-1:0] hdr;
        int                h0, e0;
        h0 = n_hdr;
        e0 = n_err;
        hdr = {r.fl[1], 7'h00, r.fl[5:4], r.fl[2], r.fl[3], r.rd ? r.addr[2:0] : 3'h0, r.rd, r.tag};
        req_valid_i <= 1'b1;
        req_read_i <= r.rd;
        req_addr_i <= r.addr;
        req_tag_i <= r.tag;
        {req_ordered_i, req_posted_i, req_source_i, req_error_i, req_test_i, req_fatal_i} <= r.fl;
        for (int n = 0; n < LINE_WORDS; n++) req_line_i[n*32 +: 32] <= {r.tag, 16'(n)};
        wait_hi(1'b0);
        req_valid_i <= 1'b0;
        wait_hi(1'b1);
        check_word(resp_link_if_i.data, hdr);
        check_bit(resp_link_if_i.fatal, r.fl[0]);
        for (int k = 0; k < (r.rd ? LINE_WORDS : STORE_DUMMY); k++) begin
            @(posedge clk_sys_i);
            check_bit(resp_link_if_i.data_valid, r.rd);
            if (r.rd) check_word(resp_link_if_i.data, {r.tag, 12'h000, 4'(r.addr[5:2] + 4'(k))});
        end
        repeat (4) @(posedge clk_sys_i);
        check_word(32'(n_hdr - h0), {31'h0, r.ex[1]});
        check_word(32'(n_err - e0), {31'h0, r.ex[0]});
        if (r.ex[0]) check_bit(err_source_o, r.fl[3]);
    endtask : run_row

    // ==========================================================
    // main sequence
    initial begin
        {clk_sys_i, req_valid_i, req_read_i, req_ordered_i, req_posted_i, req_source_i} = 6'h00;
        {req_error_i, req_test_i, req_fatal_i, out_ready_i} = 4'h0;
        {req_addr_i, req_tag_i, req_line_i} = '0;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        out_ready_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // stalled downstream holds one packet in the buffer, room drops, framer refuses, then drain
        out_ready_i <= 1'b0;
        run_row('{1'b1, 6'h04, 16'h7777, 6'b101000, 2'b00});
        check_bit(resp_link_if_i.room, 1'b0);
        check_bit(req_ready_o, 1'b0);
        check_word(out_data_o, 32'h0099_7777);
        n0 = n_out;
        out_ready_i <= 1'b1;
        repeat (30) @(posedge clk_sys_i);
        check_word(32'(n_out - n0), 32'h0000_0011);
        check_bit(out_valid_o, 1'b0);
        check_bit(resp_link_if_i.room, 1'b1);
        $display("buffer fill and drain done");
        // reset in mid-run, then recovery
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        check_bit(req_ready_o, 1'b0);
        check_bit(resp_link_if_i.room, 1'b0);
        check_bit(out_valid_o, 1'b0);
        rst_i <= 1'b0;
        run_row(rows[1]);
        $display("reset recovery done");
        final_report();
    end
endmodule : cache_dma_response_framer_test
`default_nettype wire
